/* File: common/upsg_pkg.sv */
package upsg_pkg;

    localparam logic [11:0] CFG_OFF = 12'h000;
    localparam logic [11:0] TIMEOUT_OFF = 12'h004;
    localparam logic [11:0] STATUS_OFF = 12'h008;

    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam logic [15:0] WAKE_MS = 16'h000F;
    localparam logic [15:0] WINDOW_MS = 16'h001E;
    localparam int SLEEP_S = 31;
    localparam logic [15:0] SLEEP_MS = 16'(SLEEP_S * 1000);
    localparam logic [15:0] TIMEOUT_RST = 16'h07D0;

    localparam logic [2:0] SET_OFF = 3'h0;
    localparam logic [2:0] SET_CYCLIC = 3'h1;
    localparam logic [2:0] SET_RTS = 3'h2;
    localparam logic [2:0] SET_DTR = 3'h3;
    localparam logic [2:0] SET_CYCLIC_ALT = 3'h4;
    localparam logic [2:0] VAR_DUAL_MIN = 3'h2;
    localparam logic [2:0] VAR_MAX = 3'h4;

    localparam int CFG_SET_LSB = 0;
    localparam int CFG_VAR_LSB = 4;
    localparam int CFG_FLOW_BIT = 8;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_IDLE = 2'b01,
        ST_WAKE = 2'b11
    } upsg_state_t;

    typedef struct packed {
        logic flow;
        logic [2:0] variant;
        logic [2:0] power_save_setting;
    } upsg_cfg_t;

    localparam upsg_cfg_t CFG_RST = '{flow: 1'b1, variant: 3'h0, power_save_setting: SET_OFF};

endpackage

/* File: hdl/upsg_top.sv */
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module upsg_top #(
    parameter int TICK_CYCLES = upsg_pkg::TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic txd_pin,
    input wire logic rts_n_pin,
    input wire logic dtr_n_pin,
    output logic rxd_pin,
    output logic dcd_pin,
    output logic cts_n_pin,
    output logic txd_pullup_en,
    output logic dtr_pullup_en,
    input wire logic net_registered,
    input wire logic core_tx_pending,
    input wire logic core_tx_active,
    input wire logic core_tx_bit,
    input wire logic core_aux_bit,
    output logic core_tx_allowed,
    input wire logic core_rx_char_done,
    output logic core_rxd,
    output logic core_rx_enable,
    output logic module_active
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        upsg_pkg::upsg_cfg_t cfg;
        logic [15:0] timeout_ms;
        upsg_pkg::upsg_state_t st;
        logic [15:0] tmr;
        logic [31:0] div;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic rts_prev;
        logic dtr_prev;
        logic txd_prev;
        logic rxd;
        logic dcd;
        logic cts_n;
        logic reject;
        logic [31:0] rdata;
    } upsg_regs_t;

    upsg_regs_t s_r;
    upsg_regs_t s_nxt;

    logic txd_s;
    logic rts_on;
    logic dtr_on;
    logic ms_tick;
    logic cyc_set;
    logic rx_en;
    logic tx_ok;
    logic hit_cfg;
    logic hit_tmo;
    logic hit_sts;
    logic wr_cfg;
    logic rts_rise;
    logic dtr_rise;
    logic txd_fall;
    logic [15:0] active_limit;
    upsg_pkg::upsg_cfg_t cfg_req;

    function automatic logic cfg_ok(upsg_pkg::upsg_cfg_t c);
        logic ok;
        ok = (c.power_save_setting <= upsg_pkg::SET_CYCLIC_ALT) && (c.variant <= upsg_pkg::VAR_MAX);
        if (c.power_save_setting == upsg_pkg::SET_RTS && c.flow) begin
            ok = 1'b0;
        end
        if (c.power_save_setting == upsg_pkg::SET_DTR && c.variant >= upsg_pkg::VAR_DUAL_MIN) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    // Only the second synchroniser stage is looked at; the first stays private to it.
    assign txd_s = s_r.sync2[0];
    assign rts_on = !s_r.sync2[1];
    assign dtr_on = !s_r.sync2[2];
    assign rts_rise = rts_on && s_r.rts_prev;
    assign dtr_rise = dtr_on && s_r.dtr_prev;
    assign txd_fall = !txd_s && s_r.txd_prev;
    assign ms_tick = (s_r.div == 32'(TICK_CYCLES - 1));
    assign cyc_set = (s_r.cfg.power_save_setting == upsg_pkg::SET_CYCLIC) ||
                     (s_r.cfg.power_save_setting == upsg_pkg::SET_CYCLIC_ALT);
    assign active_limit = net_registered ? s_r.timeout_ms : upsg_pkg::WINDOW_MS;

    assign hit_cfg = (paddr == upsg_pkg::CFG_OFF);
    assign hit_tmo = (paddr == upsg_pkg::TIMEOUT_OFF);
    assign hit_sts = (paddr == upsg_pkg::STATUS_OFF);
    assign wr_cfg = psel && penable && pwrite && hit_cfg;
    assign cfg_req = '{flow: pwdata[upsg_pkg::CFG_FLOW_BIT],
                       variant: pwdata[upsg_pkg::CFG_VAR_LSB +: 3],
                       power_save_setting: pwdata[upsg_pkg::CFG_SET_LSB +: 3]};

    // Host data reaches the receiver only while the port is up and its gate line is on.
    always_comb begin
        rx_en = (s_r.st == upsg_pkg::ST_ACTIVE);
        if (s_r.cfg.power_save_setting == upsg_pkg::SET_RTS && !rts_on) begin
            rx_en = 1'b0;
        end
        if (s_r.cfg.power_save_setting == upsg_pkg::SET_DTR && !dtr_on) begin
            rx_en = 1'b0;
        end
    end

    // Without flow control the host's readiness is not consulted, so unready hosts lose data.
    always_comb begin
        tx_ok = (s_r.st == upsg_pkg::ST_ACTIVE) || core_tx_pending;
        if (s_r.cfg.flow && !rts_on) begin
            tx_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = {dtr_n_pin, rts_n_pin, txd_pin};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.rts_prev = !rts_on;
        s_nxt.dtr_prev = !dtr_on;
        s_nxt.txd_prev = txd_s;
        s_nxt.div = ms_tick ? 32'h0000_0000 : s_r.div + 32'h0000_0001;
        if (ms_tick && s_r.tmr != 16'hFFFF) begin
            s_nxt.tmr = s_r.tmr + 16'h0001;
        end

        case (s_r.st)
            upsg_pkg::ST_ACTIVE: begin
                if (cyc_set) begin
                    if (core_rx_char_done || core_tx_active || core_tx_pending) begin
                        s_nxt.tmr = 16'h0000;
                    end else if (s_r.tmr >= active_limit) begin
                        s_nxt.st = upsg_pkg::ST_IDLE;
                        s_nxt.tmr = 16'h0000;
                    end
                end else if (s_r.cfg.power_save_setting == upsg_pkg::SET_RTS) begin
                    if (!rts_on && !core_tx_pending) begin
                        s_nxt.st = upsg_pkg::ST_IDLE;
                        s_nxt.tmr = 16'h0000;
                    end
                end else if (s_r.cfg.power_save_setting == upsg_pkg::SET_DTR) begin
                    if (!dtr_on && !core_tx_pending) begin
                        s_nxt.st = upsg_pkg::ST_IDLE;
                        s_nxt.tmr = 16'h0000;
                    end
                end
            end
            upsg_pkg::ST_IDLE: begin
                s_nxt.tmr = s_r.tmr;
                if (ms_tick && s_r.tmr != 16'hFFFF) begin
                    s_nxt.tmr = s_r.tmr + 16'h0001;
                end
                if (s_r.cfg.power_save_setting == upsg_pkg::SET_OFF || core_tx_pending) begin
                    s_nxt.st = upsg_pkg::ST_ACTIVE;
                    s_nxt.tmr = 16'h0000;
                end else if (cyc_set && s_r.tmr >= upsg_pkg::SLEEP_MS) begin
                    s_nxt.st = upsg_pkg::ST_ACTIVE;
                    s_nxt.tmr = 16'h0000;
                end else if (cyc_set && !s_r.cfg.flow && txd_fall) begin
                    s_nxt.st = upsg_pkg::ST_WAKE;
                    s_nxt.tmr = 16'h0000;
                end else if ((s_r.cfg.power_save_setting == upsg_pkg::SET_RTS && rts_rise) ||
                             (s_r.cfg.power_save_setting == upsg_pkg::SET_DTR && dtr_rise)) begin
                    s_nxt.st = upsg_pkg::ST_WAKE;
                    s_nxt.tmr = 16'h0000;
                end
            end
            upsg_pkg::ST_WAKE: begin
                if (s_r.cfg.power_save_setting == upsg_pkg::SET_OFF || s_r.tmr >= upsg_pkg::WAKE_MS) begin
                    s_nxt.st = upsg_pkg::ST_ACTIVE;
                    s_nxt.tmr = 16'h0000;
                end
            end
            default: begin
                s_nxt.st = upsg_pkg::ST_ACTIVE;
                s_nxt.tmr = 16'h0000;
            end
        endcase

        // RXD and DCD sit at OFF unless the core is really shifting a character out.
        s_nxt.rxd = (tx_ok && core_tx_active) ? core_tx_bit : 1'b1;
        s_nxt.dcd = (tx_ok && core_tx_active && s_r.cfg.variant >= upsg_pkg::VAR_DUAL_MIN) ?
                    core_aux_bit : 1'b1;
        if (s_r.cfg.flow) begin
            s_nxt.cts_n = (s_nxt.st != upsg_pkg::ST_ACTIVE);
        end else begin
            s_nxt.cts_n = 1'b0;
        end
        if (s_r.cfg.power_save_setting == upsg_pkg::SET_OFF) begin
            s_nxt.cts_n = 1'b0;
        end

        // A refused write leaves the old configuration in force and raises a flag.
        if (wr_cfg) begin
            if (cfg_ok(cfg_req)) begin
                s_nxt.cfg = cfg_req;
                s_nxt.reject = 1'b0;
            end else begin
                s_nxt.reject = 1'b1;
            end
        end
        if (psel && penable && pwrite && hit_tmo) begin
            s_nxt.timeout_ms = pwdata[15:0];
        end

        if (psel && !penable) begin
            if (hit_cfg) begin
                s_nxt.rdata = {23'h00_0000, s_r.cfg.flow, 1'b0, s_r.cfg.variant, 1'b0, s_r.cfg.power_save_setting};
            end else if (hit_tmo) begin
                s_nxt.rdata = {16'h0000, s_r.timeout_ms};
            end else if (hit_sts) begin
                s_nxt.rdata = {24'h00_0000, 1'b0, s_r.reject, s_r.cts_n, tx_ok, rx_en, 1'b0, s_r.st};
            end else begin
                s_nxt.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.cfg <= upsg_pkg::CFG_RST;
            s_r.timeout_ms <= upsg_pkg::TIMEOUT_RST;
            s_r.st <= upsg_pkg::ST_ACTIVE;
            s_r.tmr <= 16'h0000;
            s_r.div <= 32'h0000_0000;
            s_r.sync1 <= 3'h7;
            s_r.sync2 <= 3'h7;
            s_r.rts_prev <= 1'b1;
            s_r.dtr_prev <= 1'b1;
            s_r.txd_prev <= 1'b1;
            s_r.rxd <= 1'b1;
            s_r.dcd <= 1'b1;
            s_r.cts_n <= 1'b0;
            s_r.reject <= 1'b0;
            s_r.rdata <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign prdata = s_r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_cfg || hit_tmo || hit_sts);
    assign rxd_pin = s_r.rxd;
    assign dcd_pin = s_r.dcd;
    assign cts_n_pin = s_r.cts_n;
    assign txd_pullup_en = 1'b1;
    assign dtr_pullup_en = 1'b1;
    assign core_tx_allowed = tx_ok;
    // The host must hold back while asleep; anything it sends anyway is masked here.
    assign core_rxd = rx_en ? txd_s : 1'b1;
    assign core_rx_enable = rx_en;
    assign module_active = (s_r.st == upsg_pkg::ST_ACTIVE);

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_set0_active: assert property ((s_r.cfg.power_save_setting == upsg_pkg::SET_OFF) |=>
        (s_r.st == upsg_pkg::ST_ACTIVE)) else $error("setting zero left active mode");
    chk_set0_cts: assert property ((s_r.cfg.power_save_setting == upsg_pkg::SET_OFF) |=> !cts_n_pin)
        else $error("CTS off under setting zero");
    chk_rts_discard: assert property ((s_r.cfg.power_save_setting == upsg_pkg::SET_RTS && !rts_on) |->
        (core_rxd && !core_rx_enable)) else $error("host data passed with RTS off");
    chk_cfg_reject: assert property ((wr_cfg && !cfg_ok(cfg_req)) |=> ($stable(s_r.cfg) && s_r.reject))
        else $error("unsupported configuration accepted");
    chk_flow_hold: assert property ((s_r.cfg.flow && !rts_on) |-> !core_tx_allowed)
        else $error("transmit allowed with flow control and RTS off");
    chk_rxd_idle_high: assert property (!(core_tx_allowed && core_tx_active) |=> rxd_pin)
        else $error("RXD left OFF level while not transmitting");
    chk_rts_off_idle: assert property ((s_r.cfg.power_save_setting == upsg_pkg::SET_RTS && module_active &&
        !rts_on && !core_tx_pending && !wr_cfg) |=> (s_r.st == upsg_pkg::ST_IDLE)) else $error("RTS off kept port up");
    chk_noflow_tx: assert property ((!s_r.cfg.flow && module_active) |-> core_tx_allowed)
        else $error("transmit blocked without flow control");
    chk_char_restart: assert property ((cyc_set && module_active && core_rx_char_done && !wr_cfg) |=>
        (s_r.tmr == 16'h0000 && module_active)) else $error("character did not restart timer");
    chk_wake_bound: assert property ((s_r.st == upsg_pkg::ST_WAKE) |-> (s_r.tmr <= upsg_pkg::WAKE_MS))
        else $error("wake lasted beyond its time");
    chk_cts_flow: assert property ((s_r.cfg.flow && s_r.cfg.power_save_setting != upsg_pkg::SET_OFF &&
        $past(s_r.cfg.flow) && !wr_cfg) |-> (cts_n_pin == !module_active)) else $error("CTS disagrees with port");

endmodule

/* File: tb/upsg_host_model.sv */
`timescale 1ns/1ns
// Host side of the serial port; it turns bench requests into levels on the modem inputs.
module upsg_host_model (
    input wire logic pclk,
    input wire logic cts_n_pin,
    input wire logic rxd_pin,
    input wire logic flow_on,
    input wire logic rts_on,
    input wire logic dtr_on,
    input wire logic send_en,
    input wire logic send_bit,
    output logic txd_pin,
    output logic rts_n_pin,
    output logic dtr_n_pin,
    output logic last_rx
);
    ////////////////////////////////////////////////////////////////////////////////
    // Control lines are active low; a silent data line rests high as the pull-up leaves it.
    assign rts_n_pin = !rts_on;
    assign dtr_n_pin = !dtr_on;
    // With flow control the host keeps its data back while the modem shows CTS off.
    assign txd_pin = (send_en && !(flow_on && cts_n_pin)) ? send_bit : 1'b1;
    always_ff @(posedge pclk) begin
        last_rx <= rxd_pin;
    end
endmodule

/* File: tb/uart_power_save_gating_test.sv */
`timescale 1ns/1ns
module uart_power_save_gating_test;
    localparam int TK = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, tmo;
    logic txd, rts_n, dtr_n, rxd, dcd, cts_n, pu_t, pu_d, net_reg, tx_pend, tx_act, tx_bit, aux_bit;
    logic tx_ok, rx_done, core_rxd, rx_en, mod_act, flow_on, rts_on, dtr_on, send_en, send_bit, last_rx;
    int miscompares, n_checks, cycles, n, seed;
    logic [31:0] bad_cfg [2] = '{32'h0000_0102, 32'h0000_0123};
    logic [31:0] cyc_set [2] = '{32'h0000_0001, 32'h0000_0004};

    upsg_top #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txd_pin(txd), .rts_n_pin(rts_n), .dtr_n_pin(dtr_n), .rxd_pin(rxd), .dcd_pin(dcd), .cts_n_pin(cts_n),
        .txd_pullup_en(pu_t), .dtr_pullup_en(pu_d), .net_registered(net_reg), .core_tx_pending(tx_pend),
        .core_tx_active(tx_act), .core_tx_bit(tx_bit), .core_aux_bit(aux_bit), .core_tx_allowed(tx_ok),
        .core_rx_char_done(rx_done), .core_rxd(core_rxd), .core_rx_enable(rx_en), .module_active(mod_act));
    upsg_host_model host (.pclk(pclk), .cts_n_pin(cts_n), .rxd_pin(rxd), .flow_on(flow_on), .rts_on(rts_on),
        .dtr_on(dtr_on), .send_en(send_en), .send_bit(send_bit), .txd_pin(txd), .rts_n_pin(rts_n),
        .dtr_n_pin(dtr_n), .last_rx(last_rx));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic nap(input int k);
        repeat (k) @(negedge pclk);
    endtask

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wact(input logic v, input int hi);
        n = 0;
        while (mod_act !== v && n < hi) begin
            @(negedge pclk);
            n++;
        end
    endtask

    // A hang ends the run here instead of stalling forever.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h0000_08e4;
        {psel, penable, pwrite, paddr, pwdata, net_reg, tx_pend, tx_act, tx_bit, aux_bit, rx_done} = '0;
        {flow_on, dtr_on, send_en, send_bit} = '0;
        rts_on = 1'b1;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        nap(1);
        chk("rxd_rst", {rxd, dcd}, 2'b11);
        chk("cts_rst", cts_n, 1'b0);
        chk("active_rst", mod_act, 1'b1);
        chk("pullups", {pu_t, pu_d}, 2'b11);
        apb(0, 12'h000, 0);
        chk("cfg_rst", q, 32'h0000_0100);
        apb(0, 12'h00c, 0);
        chk("unmapped_err", e, 1'b1);
        foreach (bad_cfg[i]) begin
            apb(1, 12'h000, bad_cfg[i]);
            apb(0, 12'h000, 0);
            chk("cfg_kept", q, 32'h0000_0100);
            apb(0, 12'h008, 0);
            chk("reject_flag", q[6], 1'b1);
        end
        apb(1, 12'h000, 32'h0000_0000);
        @(posedge pclk);
        rts_on <= 1'b0;
        tx_pend <= 1'b1;
        tx_act <= 1'b1;
        send_en <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            send_bit <= 1'($random(seed));
            tx_bit <= 1'($random(seed));
            aux_bit <= 1'($random(seed));
            nap(5);
            chk("rx_follow", core_rxd, send_bit);
            chk("tx_out", {rxd, last_rx}, {tx_bit, tx_bit});
            chk("aux_idle", dcd, 1'b1);
            chk("tx_free", {tx_ok, cts_n}, 2'b10);
        end
        @(posedge pclk);
        {tx_pend, tx_act, send_bit} <= 3'b000;
        rts_on <= 1'b1;
        apb(1, 12'h000, 32'h0000_0002);
        nap(5);
        chk("rts_on_rx", core_rxd, 1'b0);
        @(posedge pclk);
        rts_on <= 1'b0;
        nap(6);
        chk("rts_off_rx", {core_rxd, rx_en, mod_act}, 3'b100);
        @(posedge pclk);
        rts_on <= 1'b1;
        wact(1, 20 * TK);
        chk("rts_wake", n >= 14 * TK && n <= 16 * TK + 8, 1'b1);
        @(posedge pclk);
        {send_en, flow_on} <= 2'b01;
        apb(1, 12'h000, 32'h0000_0103);
        @(posedge pclk);
        dtr_on <= 1'b0;
        nap(6);
        chk("dtr_off", {rx_en, cts_n}, 2'b01);
        @(posedge pclk);
        dtr_on <= 1'b1;
        wact(1, 20 * TK);
        chk("dtr_wake", n >= 14 * TK && n <= 16 * TK + 8, 1'b1);
        nap(2);
        chk("dtr_on", {rx_en, cts_n}, 2'b10);
        @(posedge pclk);
        flow_on <= 1'b0;
        foreach (cyc_set[k]) begin
            apb(1, 12'h000, cyc_set[k]);
            wact(0, 32 * TK + 20);
            chk("cyc_idle", {mod_act, rx_en}, 2'b00);
            @(posedge pclk);
            send_en <= 1'b1;
            nap(6);
            chk("first_lost", core_rxd, 1'b1);
            @(posedge pclk);
            send_bit <= 1'b1;
            wact(1, 20 * TK);
            chk("data_wake", n >= 13 * TK && n <= 16 * TK + 8, 1'b1);
            @(posedge pclk);
            send_bit <= 1'b0;
            nap(5);
            chk("later_char", core_rxd, 1'b0);
            @(posedge pclk);
            send_en <= 1'b0;
        end
        // Character pulses come every 19 cycles, just under 2 ms, below the shortest timeout drawn here.
        tmo = 3 + ($random(seed) & 3);
        apb(1, 12'h004, tmo);
        apb(0, 12'h004, 0);
        chk("tmo_rw", q, tmo);
        net_reg <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge pclk);
            rx_done <= 1'b1;
            @(posedge pclk);
            rx_done <= 1'b0;
            nap(2 * TK - 2);
        end
        chk("kept_active", mod_act, 1'b1);
        wact(0, (tmo + 2) * TK + 10);
        // The wait starts about two ticks after the last character, so those cycles are added back.
        chk("tmo_idle", n + 2 * TK >= (tmo - 1) * TK && mod_act == 1'b0, 1'b1);
        @(posedge pclk);
        rts_on <= 1'b0;
        flow_on <= 1'b1;
        apb(1, 12'h000, 32'h0000_0101);
        nap(3);
        chk("idle_cts", cts_n, 1'b1);
        @(posedge pclk);
        tx_pend <= 1'b1;
        wact(1, 20 * TK);
        nap(2);
        chk("tx_buffered", {tx_ok, cts_n}, 2'b00);
        @(posedge pclk);
        rts_on <= 1'b1;
        nap(5);
        chk("tx_release", tx_ok, 1'b1);
        apb(1, 12'h000, 32'h0000_0020);
        @(posedge pclk);
        tx_act <= 1'b1;
        aux_bit <= 1'($random(seed));
        nap(5);
        chk("aux_follow", dcd, aux_bit);
        print_verdict();
    end
endmodule
